// File: rtl/pcs_mgmt_pkg.sv
package pcs_mgmt_pkg;

    // Timing
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned LINK_TIMER_NS = 10_000_000;

    // Register addresses on the management link
    localparam logic [4:0] REG_CONTROL    = 5'h00;
    localparam logic [4:0] REG_STATUS     = 5'h01;
    localparam logic [4:0] REG_ID_HIGH    = 5'h02;
    localparam logic [4:0] REG_ID_LOW     = 5'h03;
    localparam logic [4:0] REG_ADV        = 5'h04;
    localparam logic [4:0] REG_PARTNER    = 5'h05;
    localparam logic [4:0] REG_EXPANSION  = 5'h06;
    localparam logic [4:0] REG_NP_TX      = 5'h07;
    localparam logic [4:0] REG_NP_RX      = 5'h08;
    localparam logic [4:0] REG_EXT_STATUS = 5'h0f;
    localparam logic [4:0] REG_AN_INT     = 5'h10;

    // Frame opcodes
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ  = 2'h2;

    // Field positions
    localparam int CTRL_RESET_BIT      = 15;
    localparam int CTRL_LOOPBACK_BIT   = 14;
    localparam int CTRL_AN_EN_BIT      = 12;
    localparam int CTRL_PDOWN_BIT      = 11;
    localparam int CTRL_ISOLATE_BIT    = 10;
    localparam int CTRL_AN_RESTART_BIT = 9;
    localparam int STAT_AN_CPL_BIT     = 5;
    localparam int STAT_RFAULT_BIT     = 4;
    localparam int STAT_LINK_BIT       = 2;
    localparam int ADV_RF_HI_BIT       = 13;
    localparam int ADV_RF_LO_BIT       = 12;
    localparam int NP_TOGGLE_BIT       = 11;
    localparam int EXP_PAGE_RX_BIT     = 1;
    localparam int INT_STAT_BIT        = 1;
    localparam int INT_EN_BIT          = 0;

    // Fixed values, writable masks and reset values
    localparam logic [15:0] CTRL_FIXED     = 16'h0140;
    localparam logic [15:0] CTRL_WR_MASK   = 16'hde00;
    localparam logic [15:0] STAT_FIXED     = 16'h0148;
    localparam logic [15:0] ADV_WR_MASK    = 16'hb1a0;
    localparam logic [15:0] ADV_RESET      = 16'h01a0;
    localparam logic [15:0] PARTNER_MASK   = 16'hf1e0;
    localparam logic [15:0] EXP_FIXED      = 16'h0004;
    localparam logic [15:0] NP_TX_WR_MASK  = 16'hb7ff;
    localparam logic [15:0] NP_TX_RESET    = 16'h2001;
    localparam logic [15:0] NP_RX_MASK     = 16'hffff;
    localparam logic [15:0] EXT_STATUS_VAL = 16'h8000;
    localparam logic [15:0] ZERO_WORD      = 16'h0000;
    localparam logic [9:0]  ID_MODEL_REV   = 10'h000;
    localparam logic [1:0]  ADV_RF_NONE    = 2'h0;

    // Frame bit counts (last index of each phase)
    localparam logic [4:0] HDR_LAST  = 5'h0c;
    localparam logic [4:0] TA_LAST   = 5'h01;
    localparam logic [4:0] DATA_LAST = 5'h0f;
    localparam logic [4:0] SKIP_LAST = 5'h11;

    typedef enum logic [2:0] {
        MDIO_IDLE = 3'b000,
        MDIO_HDR  = 3'b001,
        MDIO_TA   = 3'b010,
        MDIO_DATA = 3'b011,
        MDIO_SKIP = 3'b100
    } mdio_state_type;

endpackage

// File: rtl/pin_sync.sv
`timescale 1ns/1ps

module pin_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             i_mclk,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_level
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] level;
    } sync_state_type;

    sync_state_type sync_reg;
    sync_state_type sync_next;

    always_comb begin
        sync_next    = sync_reg;
        sync_next.s1 = i_async;
        sync_next.s2 = sync_reg.s1;
        sync_next.s3 = sync_reg.s2;
        // Accept a change only once two stages agree
        for (int i = 0; i < WIDTH; i++) begin
            if (sync_reg.s2[i] == sync_reg.s3[i]) begin
                sync_next.level[i] = sync_reg.s3[i];
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            sync_reg <= '{default: '1};
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign o_level = sync_reg.level;

endmodule

// File: rtl/pcs_an_mgmt_registers.sv
`timescale 1ns/1ps

// Function
// - Control bit 0.8 always reads 1, full duplex.
// - Control bit 0.7 always reads 0, collision test off.
// - Control bits 0.6 reads 1 and 0.13 reads 0, meaning 1000 Mb/s.
// - Control bits 0.5:0 read zero; writes discarded.
// - Status reports fixed abilities: 1.8, 1.6, 1.3 set, others clear.
// - Status 1.5 reads 1 once auto-negotiation completed; resets 0.
// - Status 1.4 set on remote fault, cleared by reading.
// - Status 1.2 latches low on link loss; read reloads current link.
// - Link up needs sync and, if enabled, negotiation complete.
// - Lost sync drops the link only after a full link timer.
// - Identifier registers 2 and 3 read-only; model and revision zero.
// - Pause 4.8:7 read/write reset 11; next page 4.15 reset 0.
// - Advertised fault 4.13:12 read/write; cleared on negotiation done.
// - Full duplex 4.5 read/write reset 1; other bits read zero.
// - Partner ability register 5 read-only, reset zero.
// - Expansion 6.1 set on page received, cleared on read; 6.2 is 1.
// - Next page transmit fields read/write; 7.14 reads 0; toggle 7.11 read-only.
// - Next page receive register 8 read-only, reset zero.
// - Extended status reads only 15.15 as 1.
// - Interrupt status 16.1 set on completion; cleared by writing 0 to it or by enable 16.0 at 0.
// - Interrupt status forced 0 while enable is 0.
// - Interrupt output follows 16.1; enable 16.0 resets 1.
// - Registers are reached over the serial management link.
module pcs_an_mgmt_registers
    import pcs_mgmt_pkg::*;
#(
    parameter int unsigned LINK_TIMER_CYCLES =
        (LINK_TIMER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
    parameter logic [15:0] ID_OUI_HIGH = 16'h1234,  // arbitrary value
    parameter logic [5:0]  ID_OUI_LOW  = 6'h2a       // arbitrary value
) (
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    input  wire logic        i_mdc,
    input  wire logic        i_mdio_in,
    output logic             o_mdio_out,
    output logic             o_mdio_oe,
    input  wire logic [4:0]  i_phy_addr,
    input  wire logic        i_tie_reset,
    input  wire logic        i_tie_loopback,
    input  wire logic        i_tie_an_enable,
    input  wire logic        i_tie_power_down,
    input  wire logic        i_tie_isolate,
    input  wire logic        i_sync_ok,
    input  wire logic        i_an_complete,
    input  wire logic        i_remote_fault,
    input  wire logic        i_page_rx,
    input  wire logic        i_np_tx_sent,
    input  wire logic [15:0] i_partner_ability,
    input  wire logic [15:0] i_np_rx,
    output logic             o_loopback,
    output logic             o_an_enable,
    output logic             o_power_down,
    output logic             o_isolate,
    output logic             o_pcs_reset,
    output logic             o_an_restart,
    output logic             o_link_up,
    output logic [15:0]      o_adv_ability,
    output logic [15:0]      o_np_tx,
    output logic             o_an_interrupt_out
);

    typedef struct packed {
        mdio_state_type st;
        logic [4:0]     cnt;
        logic [11:0]    hdr;
        logic [15:0]    sh;
        logic           is_rd;
        logic [4:0]     ra;
        logic           prev_mdc;
        logic           mdio_out;
        logic           mdio_oe;
        logic [15:0]    ctrl;
        logic           link_latch;
        logic           rfault;
        logic           an_done;
        logic [15:0]    adv;
        logic [15:0]    partner;
        logic           page_rx;
        logic [15:0]    np_tx;
        logic [15:0]    np_rx;
        logic           int_stat;
        logic           int_en;
        logic           an_cpl_d;
        logic           sync_good;
        logic [23:0]    ltimer;
        logic           link_up;
    } mgmt_state_type;

    mgmt_state_type st_reg;
    mgmt_state_type st_next;
    mgmt_state_type st_rst;

    logic [1:0]  pins_s;
    logic        mdc_s;
    logic        mdio_s;
    logic        mdc_rise;
    logic [12:0] hdr_word;
    logic        frame_ok;
    logic        rd_stb;
    logic        wr_en;
    logic [15:0] wr_data;
    logic [15:0] rd_word;
    logic        an_rise;
    logic        link_ok;
    logic [15:0] tie_ctrl;

    pin_sync #(
        .WIDTH (2)
    ) u_pin_sync (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_async ({i_mdc, i_mdio_in}),
        .o_level (pins_s)
    );

    assign mdc_s  = pins_s[1];
    assign mdio_s = pins_s[0];

    always_comb begin
        tie_ctrl                      = ZERO_WORD;
        tie_ctrl[CTRL_RESET_BIT]      = i_tie_reset;
        tie_ctrl[CTRL_LOOPBACK_BIT]   = i_tie_loopback;
        tie_ctrl[CTRL_AN_EN_BIT]      = i_tie_an_enable;
        tie_ctrl[CTRL_PDOWN_BIT]      = i_tie_power_down;
        tie_ctrl[CTRL_ISOLATE_BIT]    = i_tie_isolate;
    end

    always_comb begin
        st_rst          = '0;
        st_rst.st       = MDIO_IDLE;
        st_rst.prev_mdc = 1'b1;
        st_rst.ctrl     = tie_ctrl;
        st_rst.adv      = ADV_RESET;
        st_rst.np_tx    = NP_TX_RESET;
        st_rst.int_en   = 1'b1;
    end

    assign mdc_rise = mdc_s & ~st_reg.prev_mdc;
    assign hdr_word = {st_reg.hdr, mdio_s};
    assign frame_ok = hdr_word[12] && (hdr_word[9:5] == i_phy_addr) &&
                      (hdr_word[11:10] == OP_READ ||
                       hdr_word[11:10] == OP_WRITE);
    // Read side effects fire when the register is selected
    assign rd_stb   = mdc_rise && st_reg.st == MDIO_HDR &&
                      st_reg.cnt == HDR_LAST && frame_ok &&
                      hdr_word[11:10] == OP_READ;
    assign wr_en    = mdc_rise && st_reg.st == MDIO_DATA &&
                      !st_reg.is_rd && st_reg.cnt == DATA_LAST;
    assign wr_data  = {st_reg.sh[14:0], mdio_s};
    assign an_rise  = i_an_complete & ~st_reg.an_cpl_d;
    assign link_ok  = st_reg.sync_good &&
                      (!st_reg.ctrl[CTRL_AN_EN_BIT] || i_an_complete);

    // Read data of the addressed register
    always_comb begin
        rd_word = ZERO_WORD;
        if (hdr_word[4:0] == REG_CONTROL) begin
            rd_word = (st_reg.ctrl & CTRL_WR_MASK) | CTRL_FIXED;
        end else if (hdr_word[4:0] == REG_STATUS) begin
            rd_word                  = STAT_FIXED;
            rd_word[STAT_AN_CPL_BIT] = st_reg.an_done;
            rd_word[STAT_RFAULT_BIT] = st_reg.rfault;
            rd_word[STAT_LINK_BIT]   = st_reg.link_latch;
        end else if (hdr_word[4:0] == REG_ID_HIGH) begin
            rd_word = ID_OUI_HIGH;
        end else if (hdr_word[4:0] == REG_ID_LOW) begin
            rd_word = {ID_OUI_LOW, ID_MODEL_REV};
        end else if (hdr_word[4:0] == REG_ADV) begin
            rd_word = st_reg.adv & ADV_WR_MASK;
        end else if (hdr_word[4:0] == REG_PARTNER) begin
            rd_word = st_reg.partner;
        end else if (hdr_word[4:0] == REG_EXPANSION) begin
            rd_word                  = EXP_FIXED;
            rd_word[EXP_PAGE_RX_BIT] = st_reg.page_rx;
        end else if (hdr_word[4:0] == REG_NP_TX) begin
            rd_word = st_reg.np_tx;
        end else if (hdr_word[4:0] == REG_NP_RX) begin
            rd_word = st_reg.np_rx;
        end else if (hdr_word[4:0] == REG_EXT_STATUS) begin
            rd_word = EXT_STATUS_VAL;
        end else if (hdr_word[4:0] == REG_AN_INT) begin
            rd_word               = ZERO_WORD;
            rd_word[INT_STAT_BIT] = st_reg.int_stat;
            rd_word[INT_EN_BIT]   = st_reg.int_en;
        end
    end

    always_comb begin
        st_next          = st_reg;
        st_next.prev_mdc = mdc_s;

        // Serial management frame engine, steps on each MDC rising edge
        if (mdc_rise) begin
            case (st_reg.st)
                MDIO_IDLE: begin
                    if (!mdio_s) begin
                        st_next.st  = MDIO_HDR;
                        st_next.cnt = '0;
                        st_next.hdr = '0;
                    end
                end
                MDIO_HDR: begin
                    st_next.hdr = hdr_word[11:0];
                    st_next.cnt = st_reg.cnt + 5'h01;
                    if (st_reg.cnt == HDR_LAST) begin
                        st_next.cnt   = '0;
                        st_next.ra    = hdr_word[4:0];
                        st_next.is_rd = hdr_word[11:10] == OP_READ;
                        st_next.sh    = rd_word;
                        st_next.st    = frame_ok ? MDIO_TA : MDIO_SKIP;
                    end
                end
                MDIO_TA: begin
                    st_next.cnt = st_reg.cnt + 5'h01;
                    if (st_reg.is_rd) begin
                        st_next.mdio_oe  = 1'b1;
                        st_next.mdio_out = 1'b0;
                    end
                    if (st_reg.cnt == TA_LAST) begin
                        st_next.cnt = '0;
                        st_next.st  = MDIO_DATA;
                        if (st_reg.is_rd) begin
                            st_next.mdio_out = st_reg.sh[15];
                            st_next.sh       = {st_reg.sh[14:0], 1'b0};
                        end
                    end
                end
                MDIO_DATA: begin
                    st_next.cnt = st_reg.cnt + 5'h01;
                    if (st_reg.is_rd) begin
                        st_next.mdio_out = st_reg.sh[15];
                        st_next.sh       = {st_reg.sh[14:0], 1'b0};
                    end else begin
                        st_next.sh = wr_data;
                    end
                    if (st_reg.cnt == DATA_LAST) begin
                        st_next.st       = MDIO_IDLE;
                        st_next.mdio_oe  = 1'b0;
                        st_next.mdio_out = 1'b0;
                    end
                end
                MDIO_SKIP: begin
                    st_next.cnt = st_reg.cnt + 5'h01;
                    if (st_reg.cnt == SKIP_LAST) begin
                        st_next.st = MDIO_IDLE;
                    end
                end
                default: begin
                    st_next.st = MDIO_IDLE;
                end
            endcase
        end

        // Control: self-clearing strobes, tie reload on PCS reset
        st_next.ctrl[CTRL_RESET_BIT]      = 1'b0;
        st_next.ctrl[CTRL_AN_RESTART_BIT] = 1'b0;
        if (st_reg.ctrl[CTRL_RESET_BIT]) begin
            st_next.ctrl                 = tie_ctrl;
            st_next.ctrl[CTRL_RESET_BIT] = 1'b0;
        end
        if (wr_en && st_reg.ra == REG_CONTROL) begin
            st_next.ctrl = wr_data & CTRL_WR_MASK;
            // Power down is released only by a PCS reset
            if (st_reg.ctrl[CTRL_PDOWN_BIT] && !wr_data[CTRL_RESET_BIT]) begin
                st_next.ctrl[CTRL_PDOWN_BIT] = 1'b1;
            end
        end

        // Link qualification with link timer hold-off
        if (i_sync_ok) begin
            st_next.sync_good = 1'b1;
            st_next.ltimer    = '0;
        end else if (st_reg.sync_good) begin
            st_next.ltimer = st_reg.ltimer + 24'h000001;
            if (st_reg.ltimer == 24'(LINK_TIMER_CYCLES - 1)) begin
                st_next.sync_good = 1'b0;
                st_next.ltimer    = '0;
            end
        end
        st_next.link_up = link_ok;

        // Latching-low link status
        if (rd_stb && hdr_word[4:0] == REG_STATUS) begin
            st_next.link_latch = link_ok;
        end else if (!link_ok) begin
            st_next.link_latch = 1'b0;
        end

        st_next.an_done  = i_an_complete;
        st_next.an_cpl_d = i_an_complete;

        // Remote fault, set wins over clear-on-read
        st_next.rfault = i_remote_fault | (st_reg.rfault &
                         ~(rd_stb && hdr_word[4:0] == REG_STATUS));

        // Advertisement
        if (wr_en && st_reg.ra == REG_ADV) begin
            st_next.adv = wr_data & ADV_WR_MASK;
        end
        if (an_rise) begin
            st_next.adv[ADV_RF_HI_BIT:ADV_RF_LO_BIT] = ADV_RF_NONE;
        end

        st_next.partner = i_partner_ability & PARTNER_MASK;
        st_next.np_rx   = i_np_rx & NP_RX_MASK;

        // Page received, set wins over clear-on-read
        st_next.page_rx = i_page_rx | (st_reg.page_rx &
                          ~(rd_stb && hdr_word[4:0] == REG_EXPANSION));

        // Next page transmit; toggle kept out of writes
        if (wr_en && st_reg.ra == REG_NP_TX) begin
            st_next.np_tx = (wr_data & NP_TX_WR_MASK) |
                            (st_reg.np_tx & ~NP_TX_WR_MASK);
        end
        if (i_np_tx_sent) begin
            st_next.np_tx[NP_TOGGLE_BIT] = ~st_reg.np_tx[NP_TOGGLE_BIT];
        end

        // Interrupt control
        if (wr_en && st_reg.ra == REG_AN_INT) begin
            st_next.int_en = wr_data[INT_EN_BIT];
            if (!wr_data[INT_STAT_BIT]) begin
                st_next.int_stat = 1'b0;
            end
        end
        if (an_rise) begin
            st_next.int_stat = 1'b1;
        end
        if (!st_next.int_en) begin
            st_next.int_stat = 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            st_reg <= st_rst;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_mdio_out         = st_reg.mdio_out;
    assign o_mdio_oe          = st_reg.mdio_oe;
    assign o_loopback         = st_reg.ctrl[CTRL_LOOPBACK_BIT];
    assign o_an_enable        = st_reg.ctrl[CTRL_AN_EN_BIT];
    assign o_power_down       = st_reg.ctrl[CTRL_PDOWN_BIT];
    assign o_isolate          = st_reg.ctrl[CTRL_ISOLATE_BIT];
    assign o_pcs_reset        = st_reg.ctrl[CTRL_RESET_BIT];
    assign o_an_restart       = st_reg.ctrl[CTRL_AN_RESTART_BIT];
    assign o_link_up          = st_reg.link_up;
    assign o_adv_ability      = st_reg.adv;
    assign o_np_tx            = st_reg.np_tx;
    assign o_an_interrupt_out = st_reg.int_stat;

endmodule

// File: tb/mdio_host_model.sv
`timescale 1ns/1ps

module mdio_host_model
    import pcs_mgmt_pkg::*;
#(
    parameter int HALF = 5
) (
    input  wire logic i_mclk,
    input  wire logic i_mdio_out,
    input  wire logic i_mdio_oe,
    output logic      o_mdc,
    output logic      o_mdio_line
);
    logic host_oe  = 1'b0;
    logic host_bit = 1'b1;

    initial o_mdc = 1'b1;
    // Pull-up wins when neither side drives
    assign o_mdio_line = i_mdio_oe ? i_mdio_out : (host_oe ? host_bit : 1'b1);

    task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                         input logic [4:0] ra, input logic [15:0] wd,
                         output logic [15:0] rdata);
        logic [31:0] bits;
        bits = {2'b01, op, phy, ra, 2'b10, wd};
        rdata = 16'h0000;
        for (int i = 0; i < 32; i++) begin
            @(posedge i_mclk);
            o_mdc <= 1'b0;
            host_oe <= (op == OP_WRITE) || (i < 14);
            host_bit <= bits[31-i];
            repeat (HALF) @(posedge i_mclk);
            o_mdc <= 1'b1;
            if (i >= 16) begin
                rdata = {rdata[14:0], o_mdio_line};
            end
            repeat (HALF - 1) @(posedge i_mclk);
        end
        @(posedge i_mclk);
        host_oe <= 1'b0;
    endtask
endmodule

// File: tb/pcs_an_mgmt_registers_sva.sv
`timescale 1ns/1ps

module pcs_an_mgmt_checker
    import pcs_mgmt_pkg::*;
#(
    parameter int unsigned LINK_TIMER_CYCLES = 16
) (
    input wire logic        i_mclk,
    input wire logic        i_rst,
    input wire logic        i_sync_ok,
    input wire logic        i_an_complete,
    input wire logic        i_np_tx_sent,
    input wire logic        o_mdio_out,
    input wire logic        o_mdio_oe,
    input wire logic        o_link_up,
    input wire logic        o_pcs_reset,
    input wire logic        o_an_restart,
    input wire logic [15:0] o_adv_ability,
    input wire logic [15:0] o_np_tx,
    input wire logic        o_an_interrupt_out
);
    int unsigned lost_cnt;

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);

    // Consecutive cycles with sync lost
    always_ff @(posedge i_mclk) begin
        if (i_rst || i_sync_ok) begin
            lost_cnt <= 0;
        end else if (lost_cnt < 1000) begin
            lost_cnt <= lost_cnt + 1;
        end
    end

    a_adv_fixed_bits: assert property (
        (o_adv_ability & ~ADV_WR_MASK) == 16'h0000) else $error("adv bits");
    a_np_toggle_flip: assert property (
        i_np_tx_sent |=> o_np_tx[NP_TOGGLE_BIT] != $past(o_np_tx[NP_TOGGLE_BIT]))
        else $error("toggle did not flip");
    a_int_rise_cause: assert property (
        $rose(o_an_interrupt_out) |-> $past(i_an_complete))
        else $error("interrupt without completion");
    a_rf_self_clear: assert property (
        $rose(i_an_complete) |-> ##[1:2] o_adv_ability[13:12] == ADV_RF_NONE)
        else $error("fault field not cleared");
    a_link_hold_up: assert property (
        o_link_up && i_an_complete && lost_cnt + 2 < LINK_TIMER_CYCLES
        |=> o_link_up) else $error("link dropped early");
    a_link_drop_late: assert property (
        lost_cnt > LINK_TIMER_CYCLES + 2 |-> !o_link_up)
        else $error("link not dropped");
    a_ta_drive_zero: assert property (
        $rose(o_mdio_oe) |-> o_mdio_out == 1'b0) else $error("turnaround");
    a_oe_span_min: assert property (
        $rose(o_mdio_oe) |=> o_mdio_oe [*8]) else $error("drive too short");
    a_ctrl_strobe_pulse: assert property (
        o_pcs_reset || o_an_restart |=> !(o_pcs_reset || o_an_restart))
        else $error("control strobe stuck");

    c_link_up: cover property ($rose(o_link_up));
    c_int_set: cover property ($rose(o_an_interrupt_out));
    c_read_drive: cover property ($rose(o_mdio_oe));
endmodule

bind pcs_an_mgmt_registers pcs_an_mgmt_checker #(
    .LINK_TIMER_CYCLES(LINK_TIMER_CYCLES)
) chk_u (.i_mclk, .i_rst, .i_sync_ok, .i_an_complete, .i_np_tx_sent,
    .o_mdio_out, .o_mdio_oe, .o_link_up, .o_adv_ability, .o_np_tx,
    .o_pcs_reset, .o_an_restart,
    .o_an_interrupt_out);

// File: tb/pcs_an_mgmt_registers_tb_top.sv
`timescale 1ns/1ps

module pcs_an_mgmt_registers_tb_top;
    import pcs_mgmt_pkg::*;
    localparam int          LT     = 16;
    localparam logic [4:0]  PHY    = 5'h05;
    localparam logic [15:0] OUI_HI = 16'h5a3c;  // arbitrary value
    localparam logic [5:0]  OUI_LO = 6'h15;     // arbitrary value
    logic i_mclk = 1'b0, i_rst = 1'b1, i_mdc, i_mdio_in, o_mdio_out, o_mdio_oe;
    logic i_tie_isolate = 1'b0, i_sync_ok = 1'b0, i_an_complete = 1'b0;
    logic i_remote_fault, i_page_rx, i_np_tx_sent;
    logic [2:0] pulses = 3'h0;
    assign {i_remote_fault, i_page_rx, i_np_tx_sent} = pulses;
    logic [15:0] i_partner_ability = 16'h0000, i_np_rx = 16'h0000;
    logic o_loopback, o_isolate, o_link_up, o_an_interrupt_out;
    logic o_an_enable, o_power_down;
    logic [15:0] o_adv_ability, o_np_tx, w;
    int bad_count = 0, n_compared = 0;

    pcs_an_mgmt_registers #(
        .LINK_TIMER_CYCLES(LT), .ID_OUI_HIGH(OUI_HI), .ID_OUI_LOW(OUI_LO)
    ) dut_u (
        .i_mclk, .i_rst, .i_mdc, .i_mdio_in, .o_mdio_out, .o_mdio_oe,
        .i_phy_addr(PHY), .i_tie_reset(1'b0), .i_tie_loopback(1'b1),
        .i_tie_an_enable(1'b1), .i_tie_power_down(1'b0), .i_tie_isolate,
        .i_sync_ok, .i_an_complete, .i_remote_fault, .i_page_rx,
        .i_np_tx_sent, .i_partner_ability, .i_np_rx, .o_loopback,
        .o_an_enable, .o_power_down, .o_isolate, .o_pcs_reset(),
        .o_an_restart(), .o_link_up, .o_adv_ability, .o_np_tx,
        .o_an_interrupt_out);
    mdio_host_model host_u (.i_mclk, .i_mdio_out(o_mdio_out),
        .i_mdio_oe(o_mdio_oe), .o_mdc(i_mdc), .o_mdio_line(i_mdio_in));

    initial begin
        forever #25 i_mclk = ~i_mclk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [4:0] ra, input logic [15:0] exp,
                      input logic [4:0] phy = PHY);
        logic [15:0] d;
        host_u.frame(OP_READ, phy, ra, 16'h0000, d);
        chk(d, exp);
    endtask
    task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
        logic [15:0] d;
        host_u.frame(OP_WRITE, PHY, ra, wd, d);
        repeat (4) @(posedge i_mclk);
    endtask
    task automatic pulse(input logic [2:0] sel);
        @(posedge i_mclk);
        pulses <= sel;
        @(posedge i_mclk);
        pulses <= 3'h0;
        repeat (3) @(posedge i_mclk);
    endtask
    task automatic do_reset();
        @(posedge i_mclk);
        i_rst <= 1'b1;
        repeat (4) @(posedge i_mclk);
        i_rst <= 1'b0;
        repeat (6) @(posedge i_mclk);
    endtask

    task automatic t_ctrl();
        rd(REG_CONTROL, CTRL_FIXED | 16'h5000);
        wr(REG_CONTROL, 16'h10ff);
        rd(REG_CONTROL, CTRL_FIXED | 16'h1000);
        chk({15'h0, o_loopback}, 16'h0000);
        wr(REG_CONTROL, 16'h0800);
        chk({14'h0, o_power_down, o_an_enable}, 16'h0002);
        wr(REG_CONTROL, 16'h1000);
        chk({14'h0, o_power_down, o_an_enable}, 16'h0003);
        wr(REG_CONTROL, 16'h8200);
        chk({14'h0, o_power_down, o_an_enable}, 16'h0001);
        rd(REG_STATUS, STAT_FIXED);
        rd(REG_ID_HIGH, OUI_HI);
        wr(REG_ID_HIGH, 16'h0000);
        rd(REG_ID_HIGH, OUI_HI);
        rd(REG_ID_LOW, {OUI_LO, ID_MODEL_REV});
        rd(REG_EXT_STATUS, EXT_STATUS_VAL);
        rd(5'h1f, ZERO_WORD);
        rd(REG_CONTROL, 16'hffff, PHY ^ 5'h01);
        i_tie_isolate <= 1'b1;
        do_reset();
        rd(REG_CONTROL, CTRL_FIXED | 16'h5400);
        chk({15'h0, o_isolate}, 16'h0001);
    endtask

    task automatic t_adv_int();
        chk(o_adv_ability, ADV_RESET);
        wr(REG_ADV, 16'hffff);
        rd(REG_ADV, ADV_WR_MASK);
        for (int i = 0; i < 4; i++) begin
            w = {2'h0, 2'(i), 3'h0, 2'(i), 7'h20};
            wr(REG_ADV, w);
            rd(REG_ADV, w);
        end
        rd(REG_AN_INT, 16'h0001);
        i_an_complete <= 1'b1;
        repeat (4) @(posedge i_mclk);
        chk({15'h0, o_an_interrupt_out}, 16'h0001);
        rd(REG_ADV, 16'h01a0);
        rd(REG_STATUS, STAT_FIXED | 16'h0020);
        wr(REG_AN_INT, 16'h0003);
        rd(REG_AN_INT, 16'h0003);
        wr(REG_AN_INT, 16'h0001);
        rd(REG_AN_INT, 16'h0001);
        chk({15'h0, o_an_interrupt_out}, 16'h0000);
        wr(REG_AN_INT, 16'h0000);
        i_an_complete <= 1'b0;
        repeat (4) @(posedge i_mclk);
        i_an_complete <= 1'b1;
        repeat (4) @(posedge i_mclk);
        rd(REG_AN_INT, 16'h0000);
        chk({15'h0, o_an_interrupt_out}, 16'h0000);
        wr(REG_AN_INT, 16'h0001);
    endtask

    task automatic t_link();
        i_sync_ok <= 1'b1;
        repeat (4) @(posedge i_mclk);
        chk({15'h0, o_link_up}, 16'h0001);
        rd(REG_STATUS, STAT_FIXED | 16'h0020);
        rd(REG_STATUS, STAT_FIXED | 16'h0024);
        pulse(3'h4);
        rd(REG_STATUS, STAT_FIXED | 16'h0034);
        rd(REG_STATUS, STAT_FIXED | 16'h0024);
        i_sync_ok <= 1'b0;
        repeat (LT - 4) @(posedge i_mclk);
        chk({15'h0, o_link_up}, 16'h0001);
        repeat (8) @(posedge i_mclk);
        chk({15'h0, o_link_up}, 16'h0000);
        rd(REG_STATUS, STAT_FIXED | 16'h0020);
    endtask

    task automatic t_pages();
        i_partner_ability <= 16'hffff;
        i_np_rx <= 16'h5a5a;
        rd(REG_PARTNER, PARTNER_MASK);
        rd(REG_NP_RX, 16'h5a5a);
        rd(REG_EXPANSION, EXP_FIXED);
        pulse(3'h2);
        rd(REG_EXPANSION, EXP_FIXED | 16'h0002);
        rd(REG_EXPANSION, EXP_FIXED);
        rd(REG_NP_TX, NP_TX_RESET);
        wr(REG_NP_TX, 16'hffff);
        rd(REG_NP_TX, NP_TX_WR_MASK);
        pulse(3'h1);
        rd(REG_NP_TX, 16'hbfff);
        chk(o_np_tx, 16'hbfff);
    endtask

    task automatic report_and_stop();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge i_mclk);
        bad_count++;
        report_and_stop();
    end

    initial begin
        do_reset();
        t_ctrl();
        t_adv_int();
        t_link();
        t_pages();
        report_and_stop();
    end
endmodule
